// ### rbt_top.sv
`timescale 1ns/1ps

module rbt_top (
	input wire logic mclk, // system clock, 20 MHz
	input wire logic resetn, // asynchronous reset, active low
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, words only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic [31:0] hrdata, // ahb read data
	output logic hreadyout, // ahb slave ready
	output logic hresp, // ahb response
	input wire logic a_to_b_capture_clock, // stores port A on rise
	input wire logic b_to_a_capture_clock, // stores port B on rise
	input wire logic [7:0] port_a_in, // port A pin level
	output logic [7:0] port_a_out, // port A drive value
	output logic port_a_oe_n, // port A driven while low
	input wire logic [7:0] port_b_in, // port B pin level
	output logic [7:0] port_b_out, // port B drive value
	output logic port_b_oe_n, // port B driven while low
	output logic capture_ready // capture buffer has room
);

	logic rst_meta_n_q;
	logic rst_n_q;
	rbt_pkg::rbt_state_type s_q;
	rbt_pkg::rbt_state_type s_d;
	logic cap_ab;
	logic cap_ba;
	logic addr_phase;
	logic pop;
	logic clr_overflow;
	logic set_overflow;
	logic [1:0] cnt;
	logic rp;
	logic wp;
	logic drive_a;
	logic drive_b;
	rbt_pkg::rbt_reg_type addr_reg;
	logic [31:0] rdata;

	function automatic rbt_pkg::rbt_reg_type decode_reg(input logic [31:0] addr);
		rbt_pkg::rbt_reg_type r;
		r = rbt_pkg::REG_NONE;
		if (addr[31:8] == 24'h000000)
		begin
			case (addr[7:0])
				rbt_pkg::CTRL_OFFSET: r = rbt_pkg::REG_CTRL;
				rbt_pkg::STATUS_OFFSET: r = rbt_pkg::REG_STATUS;
				rbt_pkg::CAPTURE_OFFSET: r = rbt_pkg::REG_CAPTURE;
				default: r = rbt_pkg::REG_NONE;
			endcase
		end
		return r;
	endfunction

	// reset leaves through two flops so release is clean on mclk
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_n_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_n_q <= 1'b1;
			rst_n_q <= rst_meta_n_q;
		end
	end

	always_comb
	begin
		s_d = s_q;
		s_d.ab_clock_prev = a_to_b_capture_clock;
		s_d.ba_clock_prev = b_to_a_capture_clock;
		cap_ab = a_to_b_capture_clock & ~s_q.ab_clock_prev;
		cap_ba = b_to_a_capture_clock & ~s_q.ba_clock_prev;
		if (cap_ab)
		begin
			s_d.ab_word = port_a_in;
			s_d.ab_valid = 1'b1;
		end
		if (cap_ba)
		begin
			s_d.ba_word = port_b_in;
			s_d.ba_valid = 1'b1;
		end

		addr_phase = hsel & htrans[1] & hready;
		addr_reg = decode_reg(haddr);
		s_d.dph_write = addr_phase & hwrite;
		s_d.dph_reg = addr_reg;
		pop = 1'b0;
		rdata = 32'h00000000;
		if (addr_phase && !hwrite)
		begin
			case (addr_reg)
				rbt_pkg::REG_CTRL: rdata = {28'h0000000, s_q.ctrl};
				rbt_pkg::REG_STATUS: rdata = {11'h000, s_q.overflow, s_q.count,
					s_q.ba_valid, s_q.ab_valid, s_q.ba_word, s_q.ab_word};
				rbt_pkg::REG_CAPTURE:
				begin
					if (s_q.count != 2'h0)
					begin
						rdata = {1'b1, 22'h000000, s_q.fifo[s_q.rd_ptr]};
						pop = 1'b1;
					end
				end
				default: rdata = 32'h00000000;
			endcase
		end
		s_d.hrdata = rdata;
		s_d.hreadyout = 1'b1;
		s_d.hresp = rbt_pkg::HRESP_OKAY;

		clr_overflow = 1'b0;
		if (s_q.dph_write)
		begin
			case (s_q.dph_reg)
				rbt_pkg::REG_CTRL: s_d.ctrl = hwdata[3:0];
				rbt_pkg::REG_STATUS: clr_overflow = hwdata[rbt_pkg::STATUS_OVERFLOW_BIT];
				default: clr_overflow = 1'b0;
			endcase
		end

		// pop first so a full buffer drained this cycle still takes a word
		cnt = s_q.count;
		rp = s_q.rd_ptr;
		wp = s_q.wr_ptr;
		set_overflow = 1'b0;
		if (pop)
		begin
			rp = ~rp;
			cnt = cnt - 2'h1;
		end
		if (cap_ab)
		begin
			if (cnt < 2'h2)
			begin
				s_d.fifo[wp] = {1'b0, port_a_in};
				wp = ~wp;
				cnt = cnt + 2'h1;
			end
			else
				set_overflow = 1'b1;
		end
		if (cap_ba)
		begin
			if (cnt < 2'h2)
			begin
				s_d.fifo[wp] = {1'b1, port_b_in};
				wp = ~wp;
				cnt = cnt + 2'h1;
			end
			else
				set_overflow = 1'b1;
		end
		s_d.rd_ptr = rp;
		s_d.wr_ptr = wp;
		s_d.count = cnt;
		s_d.capture_ready = (cnt < 2'h2);
		// a new overflow beats a clear in the same cycle
		s_d.overflow = (s_q.overflow & ~clr_overflow) | set_overflow;

		drive_a = ~s_q.ctrl.outputs_off & ~s_q.ctrl.direction;
		drive_b = ~s_q.ctrl.outputs_off & s_q.ctrl.direction;
		s_d.port_a_oe_n = ~drive_a;
		s_d.port_b_oe_n = ~drive_b;
		s_d.port_a_out = s_q.ctrl.b_to_a_source_select ? s_q.ba_word : port_b_in;
		s_d.port_b_out = s_q.ctrl.a_to_b_source_select ? s_q.ab_word : port_a_in;
	end

	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			s_q <= '0;
			s_q.ctrl <= rbt_pkg::CTRL_RESET;
			s_q.port_a_oe_n <= 1'b1;
			s_q.port_b_oe_n <= 1'b1;
			s_q.dph_reg <= rbt_pkg::REG_NONE;
			s_q.hreadyout <= 1'b1;
			s_q.capture_ready <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign hrdata = s_q.hrdata;
	assign hreadyout = s_q.hreadyout;
	assign hresp = s_q.hresp;
	assign port_a_out = s_q.port_a_out;
	assign port_a_oe_n = s_q.port_a_oe_n;
	assign port_b_out = s_q.port_b_out;
	assign port_b_oe_n = s_q.port_b_oe_n;
	assign capture_ready = s_q.capture_ready;

	a_one_port_driven: assert property (@(posedge mclk) disable iff (!rst_n_q)
		!(!port_a_oe_n && !port_b_oe_n))
		else $error("both ports driven");

	a_isolation_off: assert property (@(posedge mclk) disable iff (!rst_n_q)
		s_q.ctrl.outputs_off |=> (port_a_oe_n && port_b_oe_n))
		else $error("port driven while outputs off");

	a_direction_port: assert property (@(posedge mclk) disable iff (!rst_n_q)
		!s_q.ctrl.outputs_off |=> (port_a_oe_n == $past(s_q.ctrl.direction))
		&& (port_b_oe_n == !$past(s_q.ctrl.direction)))
		else $error("wrong port driven for direction");

	a_ab_capture: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(a_to_b_capture_clock && !s_q.ab_clock_prev) |=> s_q.ab_word == $past(port_a_in)
		&& s_q.ab_valid)
		else $error("port A not captured");

	a_ba_capture: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(b_to_a_capture_clock && !s_q.ba_clock_prev) |=> s_q.ba_word == $past(port_b_in)
		&& s_q.ba_valid)
		else $error("port B not captured");

	a_hold_storage: assert property (@(posedge mclk) disable iff (!rst_n_q)
		!(a_to_b_capture_clock && !s_q.ab_clock_prev) |=> $stable(s_q.ab_word))
		else $error("A to B word changed without edge");

	a_live_to_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(!s_q.ctrl.outputs_off && !s_q.ctrl.direction && !s_q.ctrl.b_to_a_source_select)
		|=> !port_a_oe_n && port_a_out == $past(port_b_in))
		else $error("port A not live from B");

	a_stored_to_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(!s_q.ctrl.outputs_off && !s_q.ctrl.direction && s_q.ctrl.b_to_a_source_select)
		|=> !port_a_oe_n && port_a_out == $past(s_q.ba_word))
		else $error("port A not from stored word");

	a_live_to_b: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(!s_q.ctrl.outputs_off && s_q.ctrl.direction && !s_q.ctrl.a_to_b_source_select)
		|=> !port_b_oe_n && port_b_out == $past(port_a_in))
		else $error("port B not live from A");

	a_stored_to_b: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(!s_q.ctrl.outputs_off && s_q.ctrl.direction && s_q.ctrl.a_to_b_source_select)
		|=> !port_b_oe_n && port_b_out == $past(s_q.ab_word))
		else $error("port B not from stored word");

	a_dual_capture: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(a_to_b_capture_clock && !s_q.ab_clock_prev && b_to_a_capture_clock
		&& !s_q.ba_clock_prev) |=> s_q.ab_valid && s_q.ba_valid)
		else $error("dual capture missed");

	a_hold_ba_word: assert property (@(posedge mclk) disable iff (!rst_n_q)
		!cap_ba |=> $stable(s_q.ba_word))
		else $error("B to A word changed without edge");

	a_isolation_hold: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(s_q.ctrl.outputs_off && !cap_ab && !cap_ba)
		|=> $stable(s_q.ab_word) && $stable(s_q.ba_word))
		else $error("stored word changed in isolation");

	a_dual_capture_data: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(s_q.ctrl.outputs_off && cap_ab && cap_ba)
		|=> s_q.ab_word == $past(port_a_in) && s_q.ba_word == $past(port_b_in))
		else $error("isolation dual capture wrong");

	a_idle_port_capture: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(!s_q.ctrl.outputs_off && !s_q.ctrl.direction && cap_ba)
		|=> s_q.ba_word == $past(port_b_in))
		else $error("input port B not captured while A driven");

	a_only_a_capture: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(cap_ab && !cap_ba) |=> $stable(s_q.ba_word))
		else $error("B to A word moved on A edge");

	a_only_b_capture: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(cap_ba && !cap_ab) |=> $stable(s_q.ab_word))
		else $error("A to B word moved on B edge");

	// two-bit count must never reach three
	a_queue_bound: assert property (@(posedge mclk) disable iff (!rst_n_q)
		s_q.count <= 2'h2)
		else $error("capture queue count beyond depth");

	a_ready_room: assert property (@(posedge mclk) disable iff (!rst_n_q)
		capture_ready == (s_q.count < 2'h2))
		else $error("capture ready disagrees with queue fill");

	// a dropped word must be visible to software
	a_overflow_full: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(cap_ab && s_q.count == 2'h2 && !pop) |=> s_q.overflow)
		else $error("dropped capture not flagged");

endmodule // rbt_top

// ### rbt_pkg.sv
package rbt_pkg;

	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 2;

	// register byte addresses, word aligned
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] CAPTURE_OFFSET = 8'h08;

	// status field positions
	localparam int unsigned STATUS_AB_WORD_LSB = 0;
	localparam int unsigned STATUS_BA_WORD_LSB = 8;
	localparam int unsigned STATUS_AB_VALID_BIT = 16;
	localparam int unsigned STATUS_BA_VALID_BIT = 17;
	localparam int unsigned STATUS_COUNT_LSB = 18;
	localparam int unsigned STATUS_OVERFLOW_BIT = 20;

	// capture word field positions
	localparam int unsigned CAPTURE_DATA_LSB = 0;
	localparam int unsigned CAPTURE_SOURCE_BIT = 8;
	localparam int unsigned CAPTURE_VALID_BIT = 31;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [1:0] {
		REG_CTRL = 2'b00,
		REG_STATUS = 2'b01,
		REG_CAPTURE = 2'b10,
		REG_NONE = 2'b11
	} rbt_reg_type;

	// control bits, low to high: outputs off, direction, a_to_b select, b_to_a select
	typedef struct packed {
		logic b_to_a_source_select;
		logic a_to_b_source_select;
		logic direction;
		logic outputs_off;
	} rbt_ctrl_type;

	localparam rbt_ctrl_type CTRL_RESET = 4'h1;

	typedef struct packed {
		logic from_b;
		logic [DATA_W-1:0] data;
	} rbt_entry_type;

	typedef struct packed {
		rbt_ctrl_type ctrl;
		logic [DATA_W-1:0] ab_word;
		logic [DATA_W-1:0] ba_word;
		logic ab_valid;
		logic ba_valid;
		logic overflow;
		logic ab_clock_prev;
		logic ba_clock_prev;
		rbt_entry_type [FIFO_DEPTH-1:0] fifo;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
		logic dph_write;
		rbt_reg_type dph_reg;
		logic [DATA_W-1:0] port_a_out;
		logic [DATA_W-1:0] port_b_out;
		logic port_a_oe_n;
		logic port_b_oe_n;
		logic capture_ready;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} rbt_state_type;

endpackage

// ### rbt_bus_model.sv
`timescale 1ns/1ps

// far-side driver of one port; it backs off whenever the device drives the pin
module rbt_bus_model (
	input wire logic mclk, // system clock
	input wire logic dev_oe_n, // device drives the pin while low
	input wire logic [7:0] dev_out, // device drive value
	input wire logic [7:0] drive_val, // value this party wants on the pin
	output logic [7:0] pin // resolved pin level
);
	logic [7:0] hold_q;
	// stable around edges
	// new data only lands after an edge, so capture sees a settled level
	always_ff @(posedge mclk)
	begin
		hold_q <= drive_val;
	end
	assign pin = dev_oe_n ? hold_q : dev_out;
endmodule // rbt_bus_model

// ### rbt_top_bench.sv
`timescale 1ns/1ps

module rbt_top_bench;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp;
	logic ab_clk = 1'b0;
	logic ba_clk = 1'b0;
	logic [7:0] pa, pb, a_out, b_out, a_val, b_val;
	logic a_oe_n, b_oe_n, capture_ready;
	logic [31:0] seed, rd, ab_w, ba_w;
	int errors = 0;
	int cmp_count = 0;
	always #25 mclk = ~mclk;
	initial
	begin
		a_val = 8'h00;
		b_val = 8'h00;
	end
	rbt_top i_rbt_top (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.a_to_b_capture_clock(ab_clk), .b_to_a_capture_clock(ba_clk),
		.port_a_in(pa), .port_a_out(a_out), .port_a_oe_n(a_oe_n),
		.port_b_in(pb), .port_b_out(b_out), .port_b_oe_n(b_oe_n),
		.capture_ready(capture_ready));
	rbt_bus_model i_rbt_bus_model_a (.mclk(mclk), .dev_oe_n(a_oe_n), .dev_out(a_out),
		.drive_val(a_val), .pin(pa));
	rbt_bus_model i_rbt_bus_model_b (.mclk(mclk), .dev_oe_n(b_oe_n), .dev_out(b_out),
		.drive_val(b_val), .pin(pb));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] status_exp(input logic ovf, input logic [1:0] cnt,
		input logic [7:0] ba, input logic [7:0] ab);
		return {11'h0, ovf, cnt, 2'h3, ba, ab};
	endfunction
	task automatic report_and_stop;
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge mclk);
		end
		if (n >= 50)
		begin
			errors++;
			report_and_stop();
		end
	endtask
	// single word transfer; the bus answers with hreadyout, so no fixed latency is assumed
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= rbt_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk({31'h0, hresp}, {31'h0, rbt_pkg::HRESP_OKAY});
	endtask
	// capture clocks high for one sample, then low, so each rise is seen once
	task automatic cap(input logic a, input logic b);
		ab_clk <= a;
		ba_clk <= b;
		@(posedge mclk);
		ab_clk <= 1'b0;
		ba_clk <= 1'b0;
		@(posedge mclk);
		@(posedge mclk);
	endtask
	task automatic new_data;
		seed = lfsr(seed);
		a_val <= seed[7:0];
		b_val <= seed[15:8];
		@(posedge mclk);
		@(posedge mclk);
	endtask
	initial
	begin
		logic sel, dir;
		seed = 32'h7500;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		chk({30'h0, a_oe_n, b_oe_n}, 32'h3);
		ahb(1'b0, rbt_pkg::CTRL_OFFSET, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b0, rbt_pkg::STATUS_OFFSET, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		new_data();
		ab_w = {24'h0, a_val};
		ba_w = {24'h0, b_val};
		cap(1'b1, 1'b0);
		cap(1'b0, 1'b1);
		chk({31'h0, capture_ready}, 32'h0);
		new_data();
		cap(1'b1, 1'b1);
		ahb(1'b0, rbt_pkg::STATUS_OFFSET, 32'h0);
		// stored words show the newest capture while the queue keeps the older pair
		chk(rd, status_exp(1'b1, 2'h2, b_val, a_val));
		// queue keeps the first two words in arrival order
		ahb(1'b0, rbt_pkg::CAPTURE_OFFSET, 32'h0);
		chk(rd, 32'h80000000 | ab_w);
		ahb(1'b0, rbt_pkg::CAPTURE_OFFSET, 32'h0);
		chk(rd, 32'h80000100 | ba_w);
		ahb(1'b0, rbt_pkg::CAPTURE_OFFSET, 32'h0);
		chk(rd, 32'h0);
		ab_w = {24'h0, a_val};
		ba_w = {24'h0, b_val};
		ahb(1'b1, rbt_pkg::STATUS_OFFSET, 32'h00100000);
		ahb(1'b0, rbt_pkg::STATUS_OFFSET, 32'h0);
		chk(rd, status_exp(1'b0, 2'h0, ba_w[7:0], ab_w[7:0]));
		chk({31'h0, capture_ready}, 32'h1);
		for (int m = 0; m < 4; m++)
		begin
			dir = m[1];
			sel = m[0];
			ahb(1'b1, rbt_pkg::CTRL_OFFSET, {28'h0, sel, sel, dir, 1'b0});
			new_data();
			if (!sel)
			begin
				cap(dir, !dir);
				if (dir)
					ab_w = {24'h0, a_val};
				else
					ba_w = {24'h0, b_val};
			end
			repeat (3) @(posedge mclk);
			chk({30'h0, a_oe_n, b_oe_n}, {30'h0, dir, !dir});
			if (dir)
				chk({24'h0, b_out}, sel ? ab_w : {24'h0, a_val});
			else
				chk({24'h0, a_out}, sel ? ba_w : {24'h0, b_val});
		end
		report_and_stop();
	end
endmodule // rbt_top_bench
